/* File: rtl/scr_defs.svh */
/*
 * Register offsets, field positions, reset values and timing counts
 * of the switch configuration register bank.
 * Assumes a 100 MHz system clock and byte-addressed Wishbone words.
 */
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH

`define SCR_OFF_AUX_MODES     6'h00
`define SCR_OFF_RX_SET        6'h04
`define SCR_OFF_PULSE_1       6'h08
`define SCR_OFF_PULSE_2       6'h0c
`define SCR_OFF_EQ_1          6'h10
`define SCR_OFF_EQ_2          6'h14
`define SCR_OFF_TX_SET        6'h18
`define SCR_OFF_STATUS        6'h1c

`define SCR_AUX_CH_LSB        0
`define SCR_AUX_SM_LSB        4
`define SCR_INPUT_TERM_ENABLE_BIT         0
`define SCR_TX_PE_LSB         2

`define SCR_RST_AUX_SM        2'h0
`define SCR_RST_AUX_CH        4'h0
`define SCR_RST_INPUT_TERM_ENABLE         1'h1
`define SCR_RST_PULSE         16'h0000
`define SCR_RST_EQ            16'h0000
`define SCR_RST_TX_PE         2'h0

`define SCR_CLK_HZ            100000000
`define SCR_PULSE_MS          100
`define SCR_PULSE_CYCLES      ((`SCR_CLK_HZ / 1000) * `SCR_PULSE_MS)

`endif

/* File: rtl/scr_pkg.sv */
/*
 * Types of the switch configuration register bank.
 * Sets its own enum codes; scr_defs.svh supplies the register numbers.
 */
package scr_pkg;

    typedef enum logic [1:0] {
        SCR_AUX_QUAD    = 2'b00,
        SCR_AUX_DUAL    = 2'b01,
        SCR_AUX_SINGLE  = 2'b10,
        SCR_AUX_ILLEGAL = 2'b11
    } scr_aux_mode_t;

    typedef enum logic [0:0] {
        SCR_TERM_IDLE  = 1'b0,
        SCR_TERM_PULSE = 1'b1
    } scr_term_state_t;

endpackage : scr_pkg

/* File: rtl/scr_switch_config_registers.sv */
/*
 * Configuration register bank of a four-source video link switch:
 * auxiliary source mapping, receiver termination and equalization,
 * transmitter pre-emphasis, reached as a classic Wishbone slave.
 * Assumes one clock, a synchronous reset and a master that holds each
 * request until ack.
 */
// The Wishbone slave port and the register addresses are this design's own decisions.
// Contract
// - Dual aux maps codes 011..111 to pairs
// - Single aux: 0111 B3, 1000..1011 C0..C3
// - Single aux: 1100..1111 give D0..D3
// - Termination enable 0 disconnects, 1 connects
// - Pulse bit 0 keeps termination on switch
// - Pulse bit 1 disconnects 100 ms on switch
// - Pulse bits map B, A, C reversed, D reversed
// - Equalization bit 0 is 6 dB, 1 is 12 dB
// - Equalization vector uses pulse vector order
// - Two-bit pre-emphasis for all outputs
// - Aux mode code 11 keeps previous mode
`timescale 1ns/10ps
`include "scr_defs.svh"

module scr_switch_config_registers
    import scr_pkg::*;
#(
    parameter int unsigned PULSE_CYCLES = `SCR_PULSE_CYCLES
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [5:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Auxiliary routing: index of the source on each common line
    output logic      [4:0]  aux_common_lines_o [4],
    output logic             aux_common_valid_o [4],
    // Receiver and transmitter settings; termination in channel index order, equalization in vector order
    output logic      [15:0] input_term_connect_o,
    output logic      [15:0] equalization_level_select_o,
    output logic      [1:0]  output_emphasis_level_o
);

    localparam int unsigned CW = $clog2(PULSE_CYCLES + 1);

    // Elaboration-time refusal of a timer that cannot count
    if (PULSE_CYCLES < 1) begin : g_bad_pulse
        $error("PULSE_CYCLES must be at least one");
    end

    typedef struct packed {
        logic [31:0]     dat;
        logic            ack;
        scr_aux_mode_t   aux_mode;
        logic [3:0]      aux_ch;
        logic            term_en;
        logic [15:0]     pulse_sel;
        logic [15:0]     eq_sel;
        logic [1:0]      emph;
        scr_term_state_t tstate;
        logic [CW-1:0]   cnt;
        logic [15:0]     term;
        logic [19:0]     com;
        logic [3:0]      com_vld;
    } scr_state_t;

    scr_state_t st_r;
    scr_state_t st_nxt;

    // Channel index order of routing and termination: 0..3 A0..A3, 4..7 B, 8..11 C, 12..15 D
    function automatic logic [4:0] scr_src(input logic [1:0] grp, input logic [1:0] ch);
        scr_src = {1'b0, grp, ch};
    endfunction : scr_src

    logic        wr_hit;
    logic        rd_hit;
    logic        src_change;
    logic [1:0]  wr_mode;
    logic [3:0]  wr_ch;
    logic [7:0]  b0;

    always_comb begin
        st_nxt     = st_r;
        wr_hit     = cyc_i && stb_i && we_i && !st_r.ack;
        rd_hit     = cyc_i && stb_i && !we_i && !st_r.ack;
        src_change = 1'b0;
        b0         = dat_i[7:0];
        wr_mode    = b0[`SCR_AUX_SM_LSB +: 2];
        wr_ch      = b0[`SCR_AUX_CH_LSB +: 4];
        st_nxt.ack = cyc_i && stb_i && !st_r.ack;
        st_nxt.dat = 32'h0000_0000;

        if (wr_hit && sel_i[0]) begin
            case (adr_i)
                `SCR_OFF_AUX_MODES: begin
                    if (wr_mode != SCR_AUX_ILLEGAL) begin
                        st_nxt.aux_mode = scr_aux_mode_t'(wr_mode);
                    end
                    st_nxt.aux_ch = wr_ch;
                    src_change    = (wr_ch != st_r.aux_ch) ||
                                    ((wr_mode != SCR_AUX_ILLEGAL) &&
                                     (wr_mode != st_r.aux_mode));
                end
                `SCR_OFF_RX_SET:  st_nxt.term_en = b0[`SCR_INPUT_TERM_ENABLE_BIT];
                `SCR_OFF_PULSE_1: st_nxt.pulse_sel[7:0] = b0;
                `SCR_OFF_PULSE_2: st_nxt.pulse_sel[15:8] = b0;
                `SCR_OFF_EQ_1:    st_nxt.eq_sel[7:0] = b0;
                `SCR_OFF_EQ_2:    st_nxt.eq_sel[15:8] = b0;
                `SCR_OFF_TX_SET:  st_nxt.emph = b0[`SCR_TX_PE_LSB +: 2];
                default: begin
                end
            endcase
        end

        if (rd_hit) begin
            case (adr_i)
                `SCR_OFF_AUX_MODES: st_nxt.dat = {26'h0, st_r.aux_mode, st_r.aux_ch};
                `SCR_OFF_RX_SET:    st_nxt.dat = {31'h0, st_r.term_en};
                `SCR_OFF_PULSE_1:   st_nxt.dat = {24'h0, st_r.pulse_sel[7:0]};
                `SCR_OFF_PULSE_2:   st_nxt.dat = {24'h0, st_r.pulse_sel[15:8]};
                `SCR_OFF_EQ_1:      st_nxt.dat = {24'h0, st_r.eq_sel[7:0]};
                `SCR_OFF_EQ_2:      st_nxt.dat = {24'h0, st_r.eq_sel[15:8]};
                `SCR_OFF_TX_SET:    st_nxt.dat = {28'h0, st_r.emph, 2'h0};
                `SCR_OFF_STATUS:    st_nxt.dat = {8'h0, st_r.term, 7'h0, st_r.tstate};
                default:            st_nxt.dat = 32'h0000_0000;
            endcase
        end

        // Disconnect timer; a new switch restarts the full interval
        case (st_r.tstate)
            SCR_TERM_IDLE: begin
                if (src_change) begin
                    st_nxt.tstate = SCR_TERM_PULSE;
                    st_nxt.cnt    = CW'(PULSE_CYCLES - 1);
                end
            end
            SCR_TERM_PULSE: begin
                if (src_change) begin
                    st_nxt.cnt = CW'(PULSE_CYCLES - 1);
                end else if (st_r.cnt == '0) begin
                    st_nxt.tstate = SCR_TERM_IDLE;
                end else begin
                    st_nxt.cnt = st_r.cnt - CW'(1);
                end
            end
            default: st_nxt.tstate = SCR_TERM_IDLE;
        endcase

        // Vector bit k to channel index: B0..B3, A0..A3, C3..C0, D3..D0
        for (int k = 0; k < 16; k++) begin
            int idx;
            idx = (k < 4) ? k + 4 : (k < 8) ? k - 4 : (k < 12) ? 19 - k : 27 - k;
            st_nxt.term[idx] = st_nxt.term_en &&
                !(st_nxt.pulse_sel[k] && (st_nxt.tstate == SCR_TERM_PULSE));
        end

        // Common line routing per bundling mode
        st_nxt.com_vld = 4'hf;
        case (st_nxt.aux_mode)
            SCR_AUX_QUAD: begin
                for (int l = 0; l < 4; l++) begin
                    st_nxt.com[l*5 +: 5] = scr_src(st_nxt.aux_ch[1:0], 2'(l));
                end
            end
            SCR_AUX_DUAL: begin
                // Low pair takes A or B, high pair C or D, same channel index
                st_nxt.com[0 +: 5]  = scr_src({1'b0, st_nxt.aux_ch[2]}, st_nxt.aux_ch[1:0]);
                st_nxt.com[5 +: 5]  = scr_src({1'b0, st_nxt.aux_ch[2]}, st_nxt.aux_ch[1:0]);
                st_nxt.com[10 +: 5] = scr_src({1'b1, st_nxt.aux_ch[2]}, st_nxt.aux_ch[1:0]);
                st_nxt.com[15 +: 5] = scr_src({1'b1, st_nxt.aux_ch[2]}, st_nxt.aux_ch[1:0]);
            end
            default: begin
                // Single: every common line carries one channel
                for (int l = 0; l < 4; l++) begin
                    st_nxt.com[l*5 +: 5] = {1'b0, st_nxt.aux_ch};
                end
            end
        endcase

        if (rst_i) begin
            st_nxt          = '0;
            st_nxt.aux_mode = scr_aux_mode_t'(`SCR_RST_AUX_SM);
            st_nxt.aux_ch   = `SCR_RST_AUX_CH;
            st_nxt.term_en  = `SCR_RST_INPUT_TERM_ENABLE;
            st_nxt.pulse_sel = `SCR_RST_PULSE;
            st_nxt.eq_sel   = `SCR_RST_EQ;
            st_nxt.emph     = `SCR_RST_TX_PE;
            st_nxt.tstate   = SCR_TERM_IDLE;
            st_nxt.term     = 16'hffff;
            st_nxt.com      = {5'h3, 5'h2, 5'h1, 5'h0};
            st_nxt.com_vld  = 4'hf;
        end
    end

    always_ff @(posedge clk_i) begin
        st_r <= st_nxt;
    end

    assign dat_o                       = st_r.dat;
    assign ack_o                       = st_r.ack;
    assign input_term_connect_o        = st_r.term;
    assign equalization_level_select_o = st_r.eq_sel;
    assign output_emphasis_level_o     = st_r.emph;

    for (genvar g = 0; g < 4; g++) begin : g_com
        assign aux_common_lines_o[g] = st_r.com[g*5 +: 5];
        assign aux_common_valid_o[g] = st_r.com_vld[g];
    end

endmodule : scr_switch_config_registers

/* File: dv/scr_switch_config_registers_chk.sv */
/* Bus and settings assertions of the configuration register bank.
   Assumes binding to the top module and a master holding until ack. */
`timescale 1ns/10ps
module scr_switch_config_registers_chk (
    // Clock, reset and bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [5:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // Settings
    input wire logic [4:0]  aux_common_lines_o [4],
    input wire logic        aux_common_valid_o [4],
    input wire logic [15:0] input_term_connect_o,
    input wire logic [15:0] equalization_level_select_o,
    input wire logic [1:0]  output_emphasis_level_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Only lane 0 carries the 8-bit registers
    wire logic w = ack_o && we_i && sel_i[0];
    wire logic req = cyc_i && stb_i && we_i && !ack_o;
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
    a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data not zero");
    a_emph_write: assert property (w && adr_i == 6'h18 |->
        output_emphasis_level_o == dat_i[3:2]) else $error("emphasis not written");
    a_emph_hold: assert property (!req |=> $stable(output_emphasis_level_o))
        else $error("emphasis moved");
    a_eq_low: assert property (w && adr_i == 6'h10 |->
        equalization_level_select_o[7:0] == dat_i[7:0]) else $error("eq low wrong");
    a_eq_high: assert property (w && adr_i == 6'h14 |->
        equalization_level_select_o[15:8] == dat_i[7:0]) else $error("eq high wrong");
    a_term_off: assert property (w && adr_i == 6'h04 && !dat_i[0] |->
        input_term_connect_o == 16'h0) else $error("termination not off");
endmodule : scr_switch_config_registers_chk

bind scr_switch_config_registers scr_switch_config_registers_chk u_chk (.clk_i(clk_i),
    .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .aux_common_lines_o(aux_common_lines_o),
    .aux_common_valid_o(aux_common_valid_o), .input_term_connect_o(input_term_connect_o),
    .equalization_level_select_o(equalization_level_select_o),
    .output_emphasis_level_o(output_emphasis_level_o));

/* File: dv/scr_switch_config_registers_bench.sv */
/* Register-level bench of the configuration register bank.
   Assumes a one-cycle Wishbone answer and a shortened pulse count. */
`timescale 1ns/10ps
module scr_switch_config_registers_bench import scr_pkg::*;;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [5:0]  adr_i = 6'h0;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, q;
    logic        ack_o, vl [4];
    logic [4:0]  lo [4];
    logic [15:0] term, eq;
    logic [1:0]  emph;
    int          errors = 0, compares = 0, n;

    scr_switch_config_registers #(.PULSE_CYCLES(20)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .aux_common_lines_o(lo),
        .aux_common_valid_o(vl), .input_term_connect_o(term),
        .equalization_level_select_o(eq), .output_emphasis_level_o(emph));

    initial forever #5 clk_i = ~clk_i;

    task chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    task tally_and_finish;
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    // Ack is read just after the edge, so it is the value sampled there
    task xfer(input logic w, input logic [5:0] a, input logic [7:0] d, input logic [3:0] s);
        @(posedge clk_i);
        cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; sel_i <= s; dat_i <= {24'h0, d};
        for (n = 0; n < 9; n++) begin
            @(posedge clk_i);
            if (ack_o === 1'b1) break;
        end
        if (n < 9) begin
            q = dat_o;
            cyc_i <= 0; stb_i <= 0; we_i <= 0;
        end else begin
            errors++;
            tally_and_finish;
        end
    endtask : xfer

    task wr(input logic [5:0] a, input logic [7:0] d);
        xfer(1'b1, a, d, 4'h1);
    endtask : wr

    task rd(input logic [5:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h0, 4'h1);
        chk(q, {24'h0, e});
    endtask : rd

    task ln(input logic [19:0] e);
        chk({12'h0, lo[0], lo[1], lo[2], lo[3]}, {12'h0, e});
    endtask : ln

    initial begin
        int i;
        repeat (3) @(posedge clk_i);
        rst_i <= 0;
        rd(6'h00, 8'h00);
        rd(6'h04, 8'h01);
        for (i = 2; i < 7; i++) rd(6'(i * 4), 8'h00);
        chk(32'(term), 32'hffff);
        ln({5'd0, 5'd1, 5'd2, 5'd3});
        wr(6'h20, 8'hff);
        rd(6'h20, 8'h00);
        // Bit 3 of the select is a don't-care in dual mode
        for (i = 3; i < 8; i++) begin
            wr(6'h00, 8'(8'h18 + i));
            ln({5'(i), 5'(i), 5'(i + 8), 5'(i + 8)});
        end
        for (i = 7; i < 16; i++) begin
            wr(6'h00, 8'(8'h20 + i));
            ln({4{5'(i)}});
        end
        wr(6'h00, 8'h35);
        ln({4{5'd5}});
        rd(6'h00, 8'h25);
        wr(6'h00, 8'h02);
        ln({5'd8, 5'd9, 5'd10, 5'd11});
        chk({28'h0, vl[0], vl[1], vl[2], vl[3]}, 32'hf);
        wr(6'h10, 8'ha5);
        wr(6'h14, 8'h3c);
        chk(32'(eq), 32'h3ca5);
        rd(6'h14, 8'h3c);
        for (i = 0; i < 4; i++) begin
            wr(6'h18, 8'(i * 4));
            chk(32'(emph), 32'(i));
        end
        xfer(1'b1, 6'h18, 8'h00, 4'he);
        chk(32'(emph), 32'h3);
        repeat (25) @(posedge clk_i);
        wr(6'h08, 8'h01);
        wr(6'h0c, 8'h01);
        wr(6'h00, 8'h26);
        chk(32'(term), 32'hf7ef);
        xfer(1'b0, 6'h1c, 8'h00, 4'h1);
        chk(q, 32'h00f7_ef01);
        repeat (10) @(posedge clk_i);
        wr(6'h00, 8'h27);
        repeat (15) @(posedge clk_i);
        chk(32'(term), 32'hf7ef);
        repeat (10) @(posedge clk_i);
        chk(32'(term), 32'hffff);
        wr(6'h04, 8'h00);
        chk(32'(term), 32'h0);
        wr(6'h04, 8'h01);
        chk(32'(term), 32'hffff);
        tally_and_finish;
    end
endmodule : scr_switch_config_registers_bench
